// *** include/line_bo_pkg.sv ***
// constants for the line brown-out fault sequencer
// assumes a single 40 MHz reference clock and asynchronous active-low reset
//
// Notes on behaviour
// RQ1: line-low compare is inactive while the sense input is above the 1 V threshold.
// RQ2: when line-low asserts, connect the 980 mV hold clamp to the sense input.
// RQ3: line-low starts a 50 ms blanking timer; no fault is taken during it.
// RQ4: blanking never ends before 25 ms; shorter line dropouts are ignored.
// RQ5: when blanking ends, a 50 ms fault-detection window timer starts.
// RQ6: line-low seen inside the window confirms brown-out and raises the fault flag.
// RQ7: line-low absent for the whole window leaves the fault flag low.
// RQ8: fault flag high disables boost driver and grounds the loop control node.
// RQ9: fault flag high removes the hold clamp from the sense input.
// RQ10: fault flag high enables the 7 uA hysteresis sink.
// RQ11: lockout, on/off open, undervoltage or thermal hold input low; start with fault high.
// RQ12: once ready, release the startup pull-down and enable the hysteresis sink.
// RQ13: sink enabled in off mode; at startup disabled until supply reaches turn-on.
// RQ14: timers count clock cycles to nominal terminal counts; reset if line-low drops. Code resets only the blanking timer; the window timer keeps counting.
// RQ15: a confirmed fault clears once line-low deasserts, restarting with soft-start.
`default_nettype none

package line_bo_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int BLANK_MS = 50;
    localparam int BLANK_MIN_MS = 25;
    localparam int WINDOW_MS = 50;
    localparam int BLANK_CYCLES = CLK_HZ / 1000 * BLANK_MS;
    localparam int BLANK_MIN_CYCLES = CLK_HZ / 1000 * BLANK_MIN_MS;
    localparam int WINDOW_CYCLES = CLK_HZ / 1000 * WINDOW_MS;
    localparam int CNT_W = 32;

    typedef enum logic [2:0] {
        ST_OFF,
        ST_IDLE,
        ST_BLANK,
        ST_WINDOW,
        ST_FAULT
    } bo_state_t;
endpackage

`default_nettype wire

// *** verilog/line_brownout_fault_sequencer.sv ***
// line brown-out fault sequencer: blanking, window, fault flag and pin controls
// assumes analog status inputs are asynchronous and pass through two flip-flops
`default_nettype none

module line_brownout_fault_sequencer
    import line_bo_pkg::*;
#(
    parameter int BLANK_COUNT = BLANK_CYCLES, // RQ3 RQ4
    parameter int WINDOW_COUNT = WINDOW_CYCLES
) (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic LINE_LOW_COMPARE,
    input wire logic SUPPLY_LOCKOUT,
    input wire logic ONOFF_OPEN,
    input wire logic BULK_UNDERVOLTAGE_TRIP,
    input wire logic THERMAL_SHUTDOWN,
    input wire logic SUPPLY_TURN_ON,
    output logic LINE_FAULT_FLAG,
    output logic LINE_HOLD_CLAMP_EN,
    output logic HYSTERESIS_SINK_EN,
    output logic STARTUP_PULLDOWN_EN,
    output logic BOOST_DRIVER_DISABLE,
    output logic LOOP_CONTROL_GROUND,
    output logic BLANK_ACTIVE,
    output logic WINDOW_ACTIVE
);

    ////////////////////////////////////////////////////////////////////////
    // synchronisers: first stage feeds only the second
    // reset reads as not ready with turn-on low, so the sink cannot come on early
    localparam logic [5:0] SYNC_RESET = 6'h1E;
    logic [5:0] sync1_ff;
    logic [5:0] sync2_ff;

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            sync1_ff <= SYNC_RESET; // RQ13
            sync2_ff <= SYNC_RESET;
        end else begin
            sync1_ff <= {SUPPLY_TURN_ON, THERMAL_SHUTDOWN, BULK_UNDERVOLTAGE_TRIP,
                         ONOFF_OPEN, SUPPLY_LOCKOUT, LINE_LOW_COMPARE};
            sync2_ff <= sync1_ff;
        end
    end

    logic line_low;
    logic not_ready;
    logic turn_on;
    assign line_low = sync2_ff[0]; // RQ1
    assign not_ready = |sync2_ff[4:1];
    assign turn_on = sync2_ff[5];

    ////////////////////////////////////////////////////////////////////////
    // state machine
    bo_state_t state_ff;
    bo_state_t nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic window_hit;

    assign window_hit = (state_ff == ST_WINDOW) && line_low;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_OFF: begin
                if (!not_ready) begin
                    nxt_state = ST_FAULT; // RQ11
                end
            end
            ST_IDLE: begin
                if (line_low) begin
                    nxt_state = ST_BLANK; // RQ3
                end
            end
            ST_BLANK: begin
                if (!line_low) begin
                    nxt_state = ST_IDLE; // RQ14
                end else if (cnt_ff == CNT_W'(BLANK_COUNT - 1)) begin
                    nxt_state = ST_WINDOW; // RQ5
                end
            end
            ST_WINDOW: begin
                if (window_hit) begin
                    nxt_state = ST_FAULT; // RQ6
                end else if (cnt_ff == CNT_W'(WINDOW_COUNT - 1)) begin
                    nxt_state = ST_IDLE; // RQ7
                end
            end
            ST_FAULT: begin
                if (!line_low) begin
                    nxt_state = ST_IDLE; // RQ15
                end
            end
            default: nxt_state = ST_OFF;
        endcase
        if (not_ready) begin
            nxt_state = ST_OFF; // RQ11
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_ff <= ST_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // counter restarts on every state change
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cnt_ff <= '0;
        end else if (nxt_state != state_ff) begin
            cnt_ff <= '0; // RQ14
        end else if (state_ff == ST_BLANK || state_ff == ST_WINDOW) begin
            cnt_ff <= cnt_ff + CNT_W'(1); // RQ14
        end
    end

    // off mode remembers whether supply ever reached turn-on
    logic seen_on_ff;
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            seen_on_ff <= 1'b0;
        end else if (turn_on) begin
            seen_on_ff <= 1'b1; // RQ13
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs
    logic in_fault;
    assign in_fault = (nxt_state == ST_FAULT) || (nxt_state == ST_OFF);

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            LINE_FAULT_FLAG <= 1'b1;
            LINE_HOLD_CLAMP_EN <= 1'b0;
            HYSTERESIS_SINK_EN <= 1'b0;
            STARTUP_PULLDOWN_EN <= 1'b1;
            BOOST_DRIVER_DISABLE <= 1'b1;
            LOOP_CONTROL_GROUND <= 1'b1;
            BLANK_ACTIVE <= 1'b0;
            WINDOW_ACTIVE <= 1'b0;
        end else begin
            LINE_FAULT_FLAG <= in_fault; // RQ6 RQ7 RQ11 RQ15
            // clamp held while sequencing, dropped once fault is confirmed
            LINE_HOLD_CLAMP_EN <= (nxt_state == ST_BLANK) || (nxt_state == ST_WINDOW); // RQ2 RQ9
            HYSTERESIS_SINK_EN <= (nxt_state == ST_FAULT)
                || ((nxt_state == ST_OFF) && (seen_on_ff || turn_on)); // RQ10 RQ12 RQ13
            STARTUP_PULLDOWN_EN <= (nxt_state == ST_OFF); // RQ11 RQ12
            BOOST_DRIVER_DISABLE <= in_fault; // RQ8
            LOOP_CONTROL_GROUND <= in_fault; // RQ8
            BLANK_ACTIVE <= (nxt_state == ST_BLANK); // RQ3
            WINDOW_ACTIVE <= (nxt_state == ST_WINDOW); // RQ5
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    a_blank_no_fault: assert property (@(posedge REF_CLK) disable iff (!RSTN) // RQ3
        $rose(BLANK_ACTIVE) |-> !LINE_FAULT_FLAG [*8])
        else $error("fault raised during blanking");

    a_blank_min_len: assert property (@(posedge REF_CLK) disable iff (!RSTN) // RQ4
        $rose(WINDOW_ACTIVE) |-> $past(cnt_ff) == CNT_W'(BLANK_COUNT - 1)
            && ($past(cnt_ff) >= CNT_W'(BLANK_MIN_CYCLES - 1)
            || BLANK_COUNT < BLANK_MIN_CYCLES))
        else $error("blanking ended too early");

    a_window_fault: assert property (@(posedge REF_CLK) disable iff (!RSTN) // RQ6
        (window_hit && !not_ready) |=> LINE_FAULT_FLAG)
        else $error("line-low in window did not raise fault");

    a_window_clean: assert property (@(posedge REF_CLK) disable iff (!RSTN) // RQ7
        (state_ff == ST_WINDOW && !line_low && !not_ready) |=> !LINE_FAULT_FLAG)
        else $error("fault raised without line-low");

    a_fault_boost_off: assert property (@(posedge REF_CLK) disable iff (!RSTN) // RQ8
        LINE_FAULT_FLAG |-> BOOST_DRIVER_DISABLE && LOOP_CONTROL_GROUND)
        else $error("boost active under fault");

    a_fault_clamp_off: assert property (@(posedge REF_CLK) disable iff (!RSTN) // RQ9
        LINE_FAULT_FLAG |-> !LINE_HOLD_CLAMP_EN)
        else $error("clamp connected under fault");

    a_fault_sink_on: assert property (@(posedge REF_CLK) disable iff (!RSTN) // RQ10
        (LINE_FAULT_FLAG && !STARTUP_PULLDOWN_EN) |-> HYSTERESIS_SINK_EN)
        else $error("sink off under fault");

    a_notready_hold: assert property (@(posedge REF_CLK) disable iff (!RSTN) // RQ11
        not_ready |=> STARTUP_PULLDOWN_EN && LINE_FAULT_FLAG)
        else $error("startup hold missing");

    a_startup_sink: assert property (@(posedge REF_CLK) disable iff (!RSTN) // RQ13
        (!seen_on_ff && !turn_on) |=> !HYSTERESIS_SINK_EN)
        else $error("sink on before turn-on");

    a_fault_clear: assert property (@(posedge REF_CLK) disable iff (!RSTN) // RQ15
        (state_ff == ST_FAULT && !line_low && !not_ready) |=> !LINE_FAULT_FLAG)
        else $error("fault did not clear");

    a_clamp_on_low: assert property (@(posedge REF_CLK) disable iff (!RSTN) // RQ2
        (state_ff == ST_IDLE && line_low && !not_ready) |=> LINE_HOLD_CLAMP_EN && BLANK_ACTIVE)
        else $error("clamp not connected on line-low");

    a_ready_release: assert property (@(posedge REF_CLK) disable iff (!RSTN) // RQ12
        $fell(STARTUP_PULLDOWN_EN) |-> HYSTERESIS_SINK_EN && LINE_FAULT_FLAG)
        else $error("sink off when pull-down released");

    a_blank_restart: assert property (@(posedge REF_CLK) disable iff (!RSTN) // RQ14
        (state_ff == ST_BLANK && !line_low && !not_ready) |=> !BLANK_ACTIVE && cnt_ff == '0)
        else $error("blank timer kept running after line recovered");

    // line recovering just as blanking ends returns to idle; a window that expires without line-low closes clean
    a_window_expire: assert property (@(posedge REF_CLK) disable iff (!RSTN) // RQ7
        (state_ff == ST_WINDOW && !line_low && !not_ready
            && cnt_ff == CNT_W'(WINDOW_COUNT - 1)) |=> !WINDOW_ACTIVE && !LINE_FAULT_FLAG)
        else $error("window did not close clean");

endmodule

`default_nettype wire

// *** tb/line_front_model.sv ***
// behavioural line-sense pin: divider level, clamp, sink, pull-down and comparator
// assumes the bench sets the divider level in millivolts
`default_nettype none

module line_front_model (
    input wire logic [11:0] line_mv,
    input wire logic clamp_en,
    input wire logic sink_en,
    input wire logic pulldown_en,
    output logic line_low_compare
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] pin_mv;
    always_comb begin
        if (pulldown_en) begin
            pin_mv = 12'h000;
        end else if (clamp_en && line_mv < 12'h3D4) begin
            pin_mv = 12'h3D4;
        end else if (sink_en) begin
            // 70 mV drop stands for the sink through an arbitrary divider impedance
            pin_mv = line_mv - 12'h046;
        end else begin
            pin_mv = line_mv;
        end
        line_low_compare = pin_mv < 12'h3E8;
    end
endmodule

`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the line brown-out fault sequencer
// assumes shortened blank and window counts of 20 cycles
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BC = 20;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic turn_on = 1'b0;
    logic [3:0] off_src = 4'h1;
    logic [11:0] line_mv = 12'h5DC;
    wire cmp, flag, clamp, sink, pd, boost, loopg, blank, win;
    wire [7:0] obs = {flag, clamp, sink, pd, boost, loopg, blank, win};
    int bad_count = 0;
    int n_compared = 0;
    int n;
    initial forever #12.5 clk = ~clk;
    line_brownout_fault_sequencer #(.BLANK_COUNT(BC), .WINDOW_COUNT(BC)) u_line_brownout_fault_sequencer (
        .REF_CLK(clk), .RSTN(rstn), .LINE_LOW_COMPARE(cmp), .SUPPLY_LOCKOUT(off_src[0]),
        .ONOFF_OPEN(off_src[1]), .BULK_UNDERVOLTAGE_TRIP(off_src[2]),
        .THERMAL_SHUTDOWN(off_src[3]), .SUPPLY_TURN_ON(turn_on), .LINE_FAULT_FLAG(flag),
        .LINE_HOLD_CLAMP_EN(clamp), .HYSTERESIS_SINK_EN(sink), .STARTUP_PULLDOWN_EN(pd),
        .BOOST_DRIVER_DISABLE(boost), .LOOP_CONTROL_GROUND(loopg), .BLANK_ACTIVE(blank),
        .WINDOW_ACTIVE(win));
    line_front_model u_line_front_model (.line_mv(line_mv), .clamp_en(clamp),
        .sink_en(sink), .pulldown_en(pd), .line_low_compare(cmp));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %b seen %b", name, exp, seen);
        end
    endtask
    // counts falling edges until the chosen output reaches the level
    task automatic wait_for(input int idx, input logic val, output int cnt);
        cnt = 0;
        while (obs[idx] !== val && cnt < 200) begin
            @(negedge clk);
            cnt++;
        end
        if (cnt >= 200) begin
            check("timeout", 8'h00, 8'h01);
            results();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        check("reset_outputs", obs, 8'h9C);
        repeat (5) @(negedge clk);
        check("sink_before_turn_on", obs, 8'h9C);
        turn_on = 1'b1;
        for (int i = 0; i < 4; i++) begin
            off_src = 4'h1 << i;
            repeat (5) @(negedge clk);
            check("off_mode", obs, 8'hBC);
        end
        off_src = 4'h0;
        wait_for(4, 1'b0, n);
        check("pulldown_released", obs[4], 8'h00);
        wait_for(7, 1'b0, n);
        check("idle", obs, 8'h00);
        // short dropout must never reach the window
        line_mv = 12'h384;
        wait_for(1, 1'b1, n);
        check("blanking", obs, 8'h42);
        repeat (10) @(negedge clk);
        line_mv = 12'h5DC;
        wait_for(1, 1'b0, n);
        repeat (3) @(negedge clk);
        check("dropout_ignored", obs, 8'h00);
        // line returns just before blanking ends: the window opens and closes clean
        line_mv = 12'h384;
        wait_for(1, 1'b1, n);
        repeat (18) @(negedge clk);
        line_mv = 12'h5DC;
        wait_for(0, 1'b1, n);
        check("window_open", obs, 8'h41);
        wait_for(0, 1'b0, n);
        check("window_length", 8'(n >= BC - 1 && n <= BC + 1), 8'h01);
        check("window_clean", obs, 8'h00);
        line_mv = 12'h384;
        wait_for(1, 1'b1, n);
        wait_for(0, 1'b1, n);
        check("blank_length", 8'(n >= BC - 1 && n <= BC + 1), 8'h01);
        wait_for(7, 1'b1, n);
        check("fault_confirmed", obs, 8'hAC);
        repeat (5) @(negedge clk);
        check("fault_held", obs, 8'hAC);
        line_mv = 12'h5DC;
        wait_for(7, 1'b0, n);
        check("fault_cleared", obs, 8'h00);
        off_src = 4'h2;
        repeat (5) @(negedge clk);
        check("off_again", obs, 8'hBC);
        results();
    end
endmodule

`default_nettype wire
